// >>> tb/i2csl_asserts.sv
// Checker for the two-wire bus joining master and slave ends
`default_nettype none
module i2csl_asserts (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic m_sda_oe_n,
   input wire logic s_sda_oe_n,
   input wire logic busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       scl_q;
   logic       sda_q;
   logic [3:0] bitc;
   wire        st = scl & scl_q & sda_q & ~sda;
   wire        sp = scl & scl_q & ~sda_q & sda;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   // Clock rises since the last start, wrapping after the ninth
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bitc  <= 4'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         bitc  <= st ? 4'h0 : (scl & ~scl_q) ? ((bitc == 4'h9) ? 4'h1 : bitc + 4'h1) : bitc;
      end
   end
   sequence s_ack_low; !sda [*8]; endsequence
   property p_slv_stable; scl && $past(scl) |-> $stable(s_sda_oe_n); endproperty
   a_slv_stable: assert property (p_slv_stable) else $error("slave moved sda");
   property p_one_drv; scl |-> m_sda_oe_n || s_sda_oe_n; endproperty
   a_one_drv: assert property (p_one_drv) else $error("both ends drive sda");
   property p_ack_hold; $rose(scl) && bitc == 4'h8 && !sda |-> s_ack_low; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack not held");
   property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
   a_scl_high: assert property (p_scl_high) else $error("clock high too short");
   property p_busy_set; st |-> ##[1:80] busy_o; endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy not set");
   property p_busy_hold; sp |-> ##1 busy_o [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
   property p_busy_clr; sp |-> ##[100:400] !busy_o; endproperty
   a_busy_clr: assert property (p_busy_clr) else $error("busy stuck");
   property p_rel_idle; !busy_o |-> s_sda_oe_n; endproperty
   a_rel_idle: assert property (p_rel_idle) else $error("slave drives idle bus");
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Bench: master end talks to the slave end across the two-wire bus
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import i2csl_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        clk_link = 1'b0;
   logic        arst_n = 1'b0;
   i2csl_asel_t asel = ASEL_VBATT;
   logic        cmd_valid = 1'b0;
   i2csl_cmd_t  cmd_c = CMD_START;
   logic [7:0]  cmd_d = 8'h00;
   logic        cmd_a = 1'b0;
   logic        ready, done, ack, wr, rd_req, busy;
   logic [7:0]  rd_byte, wr_addr, wr_data, rd_addr, ra, d0, d1;
   logic [7:0]  mem [256];
   logic [15:0] exp_q [$];
   logic [7:0]  rd_q [$];
   logic [6:0]  sla [3] = '{7'h7F, 7'h7C, 7'h7D};
   int          mdl [256];
   int          fail_count = 0;
   int          n_compared = 0;
   wire  [7:0]  rd_data = mem[rd_addr];
   i2csl_if bus ();
   always #4 clk_sys_i = ~clk_sys_i;
   initial #3 forever #32 clk_link = ~clk_link;
   i2csl_master i2csl_master_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n), .bus(bus), .cmd_valid_i(cmd_valid),
      .cmd_i(cmd_c), .cmd_data_i(cmd_d), .cmd_ack_i(cmd_a), .cmd_ready_o(ready), .done_o(done),
      .rd_data_o(rd_byte), .ack_o(ack));
   i2csl_device i2csl_device_i (.clk_sys_i(clk_sys_i), .clk_link_i(clk_link), .arst_n_i(arst_n),
      .slave_address_select_pin_i(asel), .bus(bus), .wr_o(wr), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
      .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .busy_o(busy));
   i2csl_asserts i2csl_asserts_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n), .scl(bus.scl), .sda(bus.sda),
      .m_sda_oe_n(bus.m_sda_oe_n), .s_sda_oe_n(bus.s_sda_oe_n), .busy_o(busy));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cmd(input i2csl_cmd_t c, input logic [7:0] d, input logic a);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 99) begin
         @(posedge clk_sys_i);
         n++;
      end
      // A master that never comes ready falls through to the timeout report
      if (ready !== 1'b1) begin
         n = 4000;
      end
      cmd_valid <= 1'b1;
      cmd_c <= c;
      cmd_d <= d;
      cmd_a <= a;
      @(posedge clk_sys_i);
      cmd_valid <= 1'b0;
      while (done !== 1'b1 && n < 4000) begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n >= 4000) begin
         fail_count++;
         $display("unexpected %0t command timeout", $time);
         final_report;
      end
   endtask
   task automatic wb(input logic [7:0] d, input logic e);
      cmd(CMD_WRITE, d, 1'b0);
      chk({15'h0000, ack}, {15'h0000, e});
   endtask
   // Register port answers every write in order
   always @(posedge clk_sys_i) begin
      if (wr === 1'b1) begin
         mem[wr_addr] <= wr_data;
         chk({wr_addr, wr_data}, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
      end
      if (rd_req === 1'b1) begin
         chk({8'h00, rd_addr}, rd_q.size() ? {8'h00, rd_q.pop_front()} : 16'hXXXX);
      end
   end
   initial begin
      void'($urandom(32'hDEC4));
      repeat (8) @(posedge clk_sys_i);
      arst_n <= 1'b1;
      for (int s = 0; s < 3; s++) begin
         asel <= i2csl_asel_t'(s);
         ra = 8'($urandom);
         d0 = 8'($urandom);
         d1 = 8'($urandom);
         mdl[ra] = d0;
         mdl[8'(ra + 8'h01)] = d1;
         exp_q.push_back({ra, d0});
         exp_q.push_back({8'(ra + 8'h01), d1});
         // Select pin passes a link-side synchroniser first
         repeat (40) @(posedge clk_sys_i);
         cmd(CMD_START, 8'h00, 1'b0);
         wb({sla[s], 1'b0}, 1'b1);
         wb(ra, 1'b1);
         wb(d0, 1'b1);
         wb(d1, 1'b1);
         cmd(CMD_STOP, 8'h00, 1'b0);
         $display("write test %0d done", s);
      end
      cmd(CMD_START, 8'h00, 1'b0);
      wb(8'hFC, 1'b0);
      cmd(CMD_STOP, 8'h00, 1'b0);
      cmd(CMD_START, 8'h00, 1'b0);
      wb({7'h7D, 1'b0}, 1'b1);
      wb(ra, 1'b1);
      // Reads are fetched one byte ahead, so the final not-acknowledged byte still asks for the next address
      rd_q.push_back(ra);
      rd_q.push_back(8'(ra + 8'h01));
      rd_q.push_back(8'(ra + 8'h02));
      cmd(CMD_START, 8'h00, 1'b0);
      wb({7'h7D, 1'b1}, 1'b1);
      cmd(CMD_READ, 8'h00, 1'b1);
      chk({8'h00, rd_byte}, 16'(mdl[ra]));
      cmd(CMD_READ, 8'h00, 1'b0);
      chk({8'h00, rd_byte}, 16'(mdl[8'(ra + 8'h01)]));
      cmd(CMD_STOP, 8'h00, 1'b0);
      chk(16'(exp_q.size()), 16'h0000);
      chk(16'(rd_q.size()), 16'h0000);
      $display("read test done");
      final_report;
   end
endmodule
`default_nettype wire

// >>> verilog/i2csl_device.sv
// Two-wire slave end: bus framing on the link clock, register port on the system clock
`include "i2csl_regs.svh"
`default_nettype none
module i2csl_device (
   input  wire logic                   clk_sys_i,
   input  wire logic                   clk_link_i,
   input  wire logic                   arst_n_i,
   input  wire i2csl_pkg::i2csl_asel_t slave_address_select_pin_i,
   i2csl_if.slave                      bus,
   output var  logic                   wr_o,
   output var  logic [7:0]             wr_addr_o,
   output var  logic [7:0]             wr_data_o,
   output var  logic                   rd_req_o,
   output var  logic [7:0]             rd_addr_o,
   input  wire logic [7:0]             rd_data_i,
   output var  logic                   busy_o
);
   import i2csl_pkg::*;

   function automatic logic [6:0] own_address(input i2csl_asel_t sel);
      unique case (sel)
         ASEL_VBATT: own_address = `I2CSL_ADDR_VBATT;
         ASEL_FLOAT: own_address = `I2CSL_ADDR_FLOAT;
         ASEL_GND:   own_address = `I2CSL_ADDR_GND;
         default:    own_address = `I2CSL_ADDR_VBATT;
      endcase
   endfunction

   // ************************************************************
   // Link domain
   // ************************************************************
   logic          scl_f;
   logic          sda_f;
   logic          scl_q_r;
   logic          sda_q_r;
   i2csl_asel_t   asel_s1_r;
   i2csl_asel_t   asel_s2_r;
   i2csl_dstate_t st_r;
   i2csl_dstate_t st_nxt;
   i2csl_kind_t   kind_r;
   i2csl_kind_t   kind_nxt;
   logic [3:0]    cnt_r;
   logic [3:0]    cnt_nxt;
   logic [7:0]    sh_r;
   logic [7:0]    sh_nxt;
   logic          dir_r;
   logic          dir_nxt;
   logic [7:0]    reg_addr_r;
   logic [7:0]    reg_addr_nxt;
   logic          sda_oe_n_r;
   logic          sda_oe_n_nxt;
   logic          mack_r;
   logic          mack_nxt;
   logic          wr_go;
   logic          rd_go;
   logic [7:0]    rd_go_addr;
   logic          busy_r;
   logic [4:0]    bf_cnt_r;
   logic          wr_tgl_r;
   logic [7:0]    wr_addr_h_r;
   logic [7:0]    wr_data_h_r;
   logic          rd_tgl_r;
   logic [7:0]    rd_addr_h_r;
   logic [7:0]    rd_buf_r;
   logic [2:0]    rak_s_r;
   logic          rak_tgl_r;
   logic [7:0]    rd_hold_r;

   i2csl_filt u_scl_filt (
      .clk_i    (clk_link_i),
      .arst_n_i (arst_n_i),
      .din_i    (bus.scl),
      .dout_o   (scl_f)
   );
   i2csl_filt u_sda_filt (
      .clk_i    (clk_link_i),
      .arst_n_i (arst_n_i),
      .din_i    (bus.sda),
      .dout_o   (sda_f)
   );

   assign bus.s_sda_out  = 1'h0;
   assign bus.s_sda_oe_n = sda_oe_n_r;

   wire [6:0] own_addr  = own_address(asel_s2_r);
   wire       scl_rise  = scl_f & ~scl_q_r;
   wire       scl_fall  = ~scl_f & scl_q_r;
   wire       sda_hi_ch = scl_f & scl_q_r & (sda_f != sda_q_r);
   // A start or stop is preceded by one sampled bit, so only later bits count as mid-byte
   wire       mid       = ((st_r == D_RECV) | (st_r == D_SEND)) & (cnt_r >= `I2CSL_MID_MIN);
   wire       raw_start = sda_hi_ch & ~sda_f;
   wire       raw_stop  = sda_hi_ch & sda_f;
   wire       start_det = raw_start & ~mid;
   wire       stop_det  = raw_stop & ~mid;
   wire       abort_det = sda_hi_ch & mid;
   wire       byte_end  = scl_fall & (cnt_r == `I2CSL_BIT_LAST);
   wire       addr_hit  = (sh_r[7:1] == own_addr);
   wire [7:0] addr_inc  = reg_addr_r + `I2CSL_ADDR_STEP;
   wire       rak_ev    = rak_s_r[2] ^ rak_s_r[1];

   always_comb begin
      st_nxt       = st_r;
      kind_nxt     = kind_r;
      cnt_nxt      = cnt_r;
      sh_nxt       = sh_r;
      dir_nxt      = dir_r;
      reg_addr_nxt = reg_addr_r;
      sda_oe_n_nxt = sda_oe_n_r;
      mack_nxt     = mack_r;
      wr_go        = 1'h0;
      rd_go        = 1'h0;
      rd_go_addr   = reg_addr_r;
      if (start_det) begin
         st_nxt       = D_RECV;
         kind_nxt     = K_SLA;
         cnt_nxt      = 4'h0;
         sda_oe_n_nxt = 1'h1;
      end else if (stop_det | abort_det) begin
         st_nxt       = D_IDLE;
         cnt_nxt      = 4'h0;
         sda_oe_n_nxt = 1'h1;
      end else begin
         unique case (st_r)
            D_IDLE: begin
            end
            D_RECV: begin
               if (scl_rise) begin
                  sh_nxt  = {sh_r[6:0], sda_f};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (byte_end) begin
                  cnt_nxt = 4'h0;
                  if (kind_r == K_SLA) begin
                     dir_nxt = sh_r[0];
                     rd_go   = addr_hit & sh_r[0];
                  end
                  st_nxt       = (kind_r == K_SLA && !addr_hit) ? D_IDLE : D_ACK;
                  sda_oe_n_nxt = (kind_r == K_SLA && !addr_hit);
                  if (kind_r == K_REGA) begin
                     reg_addr_nxt = sh_r;
                  end
                  wr_go = (kind_r == K_DATA);
               end
            end
            D_ACK: begin
               if (scl_fall) begin
                  if (kind_r == K_SLA && dir_r) begin
                     st_nxt       = D_SEND;
                     sh_nxt       = rd_buf_r;
                     sda_oe_n_nxt = rd_buf_r[7];
                  end else begin
                     st_nxt       = D_RECV;
                     kind_nxt     = (kind_r == K_SLA) ? K_REGA : K_DATA;
                     sda_oe_n_nxt = 1'h1;
                  end
                  if (kind_r == K_DATA) begin
                     reg_addr_nxt = addr_inc;
                  end
               end
            end
            D_SEND: begin
               if (scl_rise) begin
                  cnt_nxt = cnt_r + 4'h1;
               end else if (byte_end) begin
                  st_nxt       = D_MACK;
                  cnt_nxt      = 4'h0;
                  sda_oe_n_nxt = 1'h1;
                  rd_go        = 1'h1;
                  rd_go_addr   = addr_inc;
               end else if (scl_fall) begin
                  sh_nxt       = {sh_r[6:0], 1'h1};
                  sda_oe_n_nxt = sh_r[6];
               end
            end
            D_MACK: begin
               if (scl_rise) begin
                  mack_nxt = ~sda_f;
               end else if (scl_fall) begin
                  st_nxt = mack_r ? D_SEND : D_IDLE;
                  if (mack_r) begin
                     reg_addr_nxt = addr_inc;
                     sh_nxt       = rd_buf_r;
                     sda_oe_n_nxt = rd_buf_r[7];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_link_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_q_r     <= 1'h1;
         sda_q_r     <= 1'h1;
         asel_s1_r   <= ASEL_VBATT;
         asel_s2_r   <= ASEL_VBATT;
         st_r        <= D_IDLE;
         kind_r      <= K_SLA;
         cnt_r       <= 4'h0;
         sh_r        <= 8'h00;
         dir_r       <= 1'h0;
         reg_addr_r  <= 8'h00;
         sda_oe_n_r  <= 1'h1;
         mack_r      <= 1'h0;
         wr_tgl_r    <= 1'h0;
         wr_addr_h_r <= 8'h00;
         wr_data_h_r <= 8'h00;
         rd_tgl_r    <= 1'h0;
         rd_addr_h_r <= 8'h00;
         rd_buf_r    <= 8'hFF;
         rak_s_r     <= 3'h0;
      end else begin
         scl_q_r    <= scl_f;
         sda_q_r    <= sda_f;
         asel_s1_r  <= slave_address_select_pin_i;
         asel_s2_r  <= asel_s1_r;
         st_r       <= st_nxt;
         kind_r     <= kind_nxt;
         cnt_r      <= cnt_nxt;
         sh_r       <= sh_nxt;
         dir_r      <= dir_nxt;
         reg_addr_r <= reg_addr_nxt;
         sda_oe_n_r <= sda_oe_n_nxt;
         mack_r     <= mack_nxt;
         rak_s_r    <= {rak_s_r[1:0], rak_tgl_r};
         if (wr_go) begin
            wr_tgl_r    <= ~wr_tgl_r;
            wr_addr_h_r <= reg_addr_r;
            wr_data_h_r <= sh_r;
         end
         if (rd_go) begin
            rd_tgl_r    <= ~rd_tgl_r;
            rd_addr_h_r <= rd_go_addr;
         end
         if (rak_ev) begin
            rd_buf_r <= rd_hold_r;
         end
      end
   end

   // busy until bus-free time after stop
   always_ff @(posedge clk_link_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_r   <= 1'h0;
         bf_cnt_r <= 5'h00;
      end else if (raw_start) begin
         busy_r   <= 1'h1;
         bf_cnt_r <= 5'h00;
      end else if (raw_stop && busy_r) begin
         bf_cnt_r <= `I2CSL_BUSY_CYC;
      end else if (bf_cnt_r != 5'h00) begin
         bf_cnt_r <= bf_cnt_r - 5'h01;
         busy_r   <= (bf_cnt_r != 5'h01);
      end
   end

   // ************************************************************
   // System domain
   // ************************************************************
   // Held words stay still for a whole byte time, far longer than a toggle crossing takes
   logic [2:0] wr_s_r;
   logic [2:0] rd_s_r;
   logic [1:0] busy_s_r;
   logic       wr_r;
   logic [7:0] wr_addr_r;
   logic [7:0] wr_data_r;
   logic       rd_req_r;
   logic [7:0] rd_addr_r;

   wire wr_ev = wr_s_r[2] ^ wr_s_r[1];
   wire rd_ev = rd_s_r[2] ^ rd_s_r[1];

   assign wr_o      = wr_r;
   assign wr_addr_o = wr_addr_r;
   assign wr_data_o = wr_data_r;
   assign rd_req_o  = rd_req_r;
   assign rd_addr_o = rd_addr_r;
   assign busy_o    = busy_s_r[1];

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_s_r    <= 3'h0;
         rd_s_r    <= 3'h0;
         busy_s_r  <= 2'h0;
         wr_r      <= 1'h0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
         rd_req_r  <= 1'h0;
         rd_addr_r <= 8'h00;
         rak_tgl_r <= 1'h0;
         rd_hold_r <= 8'hFF;
      end else begin
         wr_s_r   <= {wr_s_r[1:0], wr_tgl_r};
         rd_s_r   <= {rd_s_r[1:0], rd_tgl_r};
         busy_s_r <= {busy_s_r[0], busy_r};
         wr_r     <= wr_ev;
         rd_req_r <= rd_ev;
         if (wr_ev) begin
            wr_addr_r <= wr_addr_h_r;
            wr_data_r <= wr_data_h_r;
         end
         if (rd_ev) begin
            rd_addr_r <= rd_addr_h_r;
         end
         if (rd_req_r) begin
            rd_hold_r <= rd_data_i;
            rak_tgl_r <= ~rak_tgl_r;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verilog/i2csl_filt.sv
// Two-stage synchroniser followed by a spike filter for one bus line
`include "i2csl_regs.svh"
`default_nettype none
module i2csl_filt (
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic din_i,
   output var  logic dout_o
);
   logic       s1_r;
   logic       s2_r;
   logic [2:0] cnt_r;
   logic       out_r;

   wire differ = (s2_r != out_r);
   wire accept = differ & (cnt_r == `I2CSL_FILT_LAST);

   assign dout_o = out_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_r  <= 1'h1;
         s2_r  <= 1'h1;
         cnt_r <= 3'h0;
         out_r <= 1'h1;
      end else begin
         s1_r  <= din_i;
         s2_r  <= s1_r;
         cnt_r <= (differ & !accept) ? cnt_r + 3'h1 : 3'h0;
         if (accept) begin
            out_r <= s2_r;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verilog/i2csl_if.sv
// Open-drain two-wire bus joining the master end and the slave end
`default_nettype none
interface i2csl_if;
   logic m_scl_out;
   logic m_scl_oe_n;
   logic m_sda_out;
   logic m_sda_oe_n;
   logic s_sda_out;
   logic s_sda_oe_n;
   logic scl;
   logic sda;

   // Released lines float high through the pull-up; any driver wins low
   assign scl = m_scl_oe_n | m_scl_out;
   assign sda = (m_sda_oe_n | m_sda_out) & (s_sda_oe_n | s_sda_out);

   modport master (output m_scl_out, output m_scl_oe_n, output m_sda_out, output m_sda_oe_n,
                   input scl, input sda);
   modport slave  (output s_sda_out, output s_sda_oe_n, input scl, input sda);
endinterface
`default_nettype wire

// >>> verilog/i2csl_master.sv
// Two-wire master end: makes SCL by division and frames start, stop and byte commands
`include "i2csl_regs.svh"
`default_nettype none
module i2csl_master (
   input  wire logic                  clk_sys_i,
   input  wire logic                  arst_n_i,
   i2csl_if.master                    bus,
   input  wire logic                  cmd_valid_i,
   input  wire i2csl_pkg::i2csl_cmd_t cmd_i,
   input  wire logic [7:0]            cmd_data_i,
   input  wire logic                  cmd_ack_i,
   output var  logic                  cmd_ready_o,
   output var  logic                  done_o,
   output var  logic [7:0]            rd_data_o,
   output var  logic                  ack_o
);
   import i2csl_pkg::*;

   i2csl_mstate_t st_r;
   i2csl_mstate_t st_nxt;
   logic [1:0]    ph_r;
   logic [1:0]    ph_nxt;
   logic [7:0]    tmr_r;
   logic [7:0]    tmr_nxt;
   logic [3:0]    cnt_r;
   logic [3:0]    cnt_nxt;
   logic [8:0]    tx_r;
   logic [8:0]    tx_nxt;
   logic [8:0]    rx_r;
   logic [8:0]    rx_nxt;
   logic          scl_oe_n_r;
   logic          scl_oe_n_nxt;
   logic          sda_oe_n_r;
   logic          sda_oe_n_nxt;
   logic          finish;
   logic [1:0]    sda_s_r;
   logic          ready_r;
   logic          done_r;
   logic [7:0]    rd_data_r;
   logic          ack_r;

   wire accept = cmd_valid_i & ready_r & (st_r == M_IDLE);
   wire step   = (tmr_r == 8'h00) & (st_r != M_IDLE);

   assign bus.m_scl_out  = 1'h0;
   assign bus.m_sda_out  = 1'h0;
   assign bus.m_scl_oe_n = scl_oe_n_r;
   assign bus.m_sda_oe_n = sda_oe_n_r;
   assign cmd_ready_o    = ready_r;
   assign done_o         = done_r;
   assign rd_data_o      = rd_data_r;
   assign ack_o          = ack_r;

   // Timer loads hold the full count, so each wait lasts one cycle more since the zero cycle itself counts
   always_comb begin
      st_nxt       = st_r;
      ph_nxt       = ph_r;
      tmr_nxt      = (tmr_r != 8'h00) ? tmr_r - 8'h01 : 8'h00;
      cnt_nxt      = cnt_r;
      tx_nxt       = tx_r;
      rx_nxt       = rx_r;
      scl_oe_n_nxt = scl_oe_n_r;
      sda_oe_n_nxt = sda_oe_n_r;
      finish       = 1'h0;
      if (accept) begin
         ph_nxt  = 2'h0;
         cnt_nxt = 4'h0;
         tmr_nxt = `I2CSL_LOW_HALF_CYC;
         unique case (cmd_i)
            CMD_START: begin
               st_nxt       = M_START;
               sda_oe_n_nxt = 1'h1;
            end
            CMD_STOP: begin
               st_nxt       = M_STOP;
               sda_oe_n_nxt = 1'h0;
            end
            CMD_WRITE, CMD_READ: begin
               // release for slave ack on writes
               st_nxt       = M_BIT;
               tx_nxt       = (cmd_i == CMD_WRITE) ? {cmd_data_i, 1'h1} : {8'hFF, ~cmd_ack_i};
               sda_oe_n_nxt = tx_nxt[8];
            end
         endcase
      end else if (step) begin
         ph_nxt = ph_r + 2'h1;
         unique case (st_r)
            M_IDLE: begin
            end
            // master alone makes start and stop
            M_START: begin
               unique case (ph_r)
                  2'h0: begin scl_oe_n_nxt = 1'h1; tmr_nxt = `I2CSL_SU_CYC; end
                  2'h1: begin sda_oe_n_nxt = 1'h0; tmr_nxt = `I2CSL_HD_CYC; end
                  2'h2: begin scl_oe_n_nxt = 1'h0; tmr_nxt = `I2CSL_LOW_HALF_CYC; end
                  2'h3: finish = 1'h1;
               endcase
            end
            M_BIT: begin
               unique case (ph_r)
                  2'h0: begin scl_oe_n_nxt = 1'h1; tmr_nxt = `I2CSL_HIGH_CYC; end
                  2'h1: begin
                     rx_nxt       = {rx_r[7:0], sda_s_r[1]};
                     scl_oe_n_nxt = 1'h0;
                     tmr_nxt      = `I2CSL_LOW_HALF_CYC;
                  end
                  default: begin
                     if (cnt_r == `I2CSL_BIT_LAST) begin
                        finish = 1'h1;
                     end else begin
                        ph_nxt       = 2'h0;
                        cnt_nxt      = cnt_r + 4'h1;
                        tx_nxt       = {tx_r[7:0], 1'h1};
                        sda_oe_n_nxt = tx_r[7];
                        tmr_nxt      = `I2CSL_LOW_HALF_CYC;
                     end
                  end
               endcase
            end
            M_STOP: begin
               unique case (ph_r)
                  2'h0: begin scl_oe_n_nxt = 1'h1; tmr_nxt = `I2CSL_SU_CYC; end
                  2'h1: begin sda_oe_n_nxt = 1'h1; tmr_nxt = `I2CSL_BF_CYC; end
                  default: finish = 1'h1;
               endcase
            end
         endcase
         if (finish) begin
            st_nxt = M_IDLE;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r       <= M_IDLE;
         ph_r       <= 2'h0;
         tmr_r      <= 8'h00;
         cnt_r      <= 4'h0;
         tx_r       <= 9'h1FF;
         rx_r       <= 9'h000;
         scl_oe_n_r <= 1'h1;
         sda_oe_n_r <= 1'h1;
         sda_s_r    <= 2'h3;
         ready_r    <= 1'h0;
         done_r     <= 1'h0;
         rd_data_r  <= 8'h00;
         ack_r      <= 1'h0;
      end else begin
         st_r       <= st_nxt;
         ph_r       <= ph_nxt;
         tmr_r      <= tmr_nxt;
         cnt_r      <= cnt_nxt;
         tx_r       <= tx_nxt;
         rx_r       <= rx_nxt;
         scl_oe_n_r <= scl_oe_n_nxt;
         sda_oe_n_r <= sda_oe_n_nxt;
         sda_s_r    <= {sda_s_r[0], bus.sda};
         ready_r    <= (st_nxt == M_IDLE) & !accept;
         done_r     <= finish;
         if (finish && st_r == M_BIT) begin
            rd_data_r <= rx_r[8:1];
            ack_r     <= ~rx_r[0];
         end
      end
   end
endmodule
`default_nettype wire

// >>> verilog/i2csl_pkg.sv
// Types shared by both ends of the two-wire slave port
`default_nettype none
package i2csl_pkg;
   typedef enum logic [1:0] {ASEL_VBATT, ASEL_FLOAT, ASEL_GND} i2csl_asel_t;
   typedef enum logic [2:0] {D_IDLE, D_RECV, D_ACK, D_SEND, D_MACK} i2csl_dstate_t;
   typedef enum logic [1:0] {K_SLA, K_REGA, K_DATA} i2csl_kind_t;
   typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} i2csl_mstate_t;
   typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} i2csl_cmd_t;
endpackage
`default_nettype wire

// >>> verilog/i2csl_regs.svh
// Timing counts, addresses and bit counts of the two-wire slave port and its master end
`ifndef I2CSL_REGS_SVH
`define I2CSL_REGS_SVH

`define I2CSL_CEIL(t, p)          (((t) + (p) - 1) / (p))

`define I2CSL_SYS_PERIOD_NS       8
`define I2CSL_LINK_PERIOD_NS      64
`define I2CSL_T_SPIKE_NS          50
`define I2CSL_T_BUSFREE_NS        1300
`define I2CSL_T_SCL_PERIOD_NS     2500
`define I2CSL_T_LOW_NS            1300
`define I2CSL_T_SU_NS             600
`define I2CSL_T_HD_STA_NS         600

// Link-clock counts on the device end
`define I2CSL_FILT_LAST           3'(`I2CSL_CEIL(`I2CSL_T_SPIKE_NS, `I2CSL_LINK_PERIOD_NS))
`define I2CSL_BUSY_CYC            5'(`I2CSL_CEIL(`I2CSL_T_BUSFREE_NS, `I2CSL_LINK_PERIOD_NS))

// System-clock counts on the master end
`define I2CSL_LOW_HALF_CYC        8'(`I2CSL_CEIL(`I2CSL_T_LOW_NS, 2 * `I2CSL_SYS_PERIOD_NS))
`define I2CSL_HIGH_CYC            8'(`I2CSL_CEIL(`I2CSL_T_SCL_PERIOD_NS - `I2CSL_T_LOW_NS, `I2CSL_SYS_PERIOD_NS))
`define I2CSL_SU_CYC              8'(`I2CSL_CEIL(`I2CSL_T_SU_NS, `I2CSL_SYS_PERIOD_NS))
`define I2CSL_HD_CYC              8'(`I2CSL_CEIL(`I2CSL_T_HD_STA_NS, `I2CSL_SYS_PERIOD_NS))
`define I2CSL_BF_CYC              8'(`I2CSL_CEIL(`I2CSL_T_BUSFREE_NS, `I2CSL_SYS_PERIOD_NS))

`define I2CSL_ADDR_VBATT          7'h7F
`define I2CSL_ADDR_FLOAT          7'h7C
`define I2CSL_ADDR_GND            7'h7D

`define I2CSL_BIT_LAST            4'h8
`define I2CSL_MID_MIN             4'h2
`define I2CSL_ADDR_STEP           8'h01

`endif
